// ===== common/ccs_pkg.sv
// constants and types for the constant-current chop sequencer
package ccs_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CLK_KHZ = 250000;
    // chop period length in oscillator counts
    localparam int unsigned CHOP_COUNTS = 16;
    // internal fixed chop oscillator frequency
    localparam int unsigned CHOP_OSC_KHZ = 920;
    localparam int unsigned OSC_DIV_CYC = CLK_KHZ / CHOP_OSC_KHZ;
    // times in ns as printed
    localparam int unsigned DEAD_NS = 400;
    localparam int unsigned LIMIT_BLANK_NS = 1250;
    localparam int unsigned DECAY_BLANK_NS = 2200;
    localparam int unsigned FILTER_NS = 350;
    localparam int unsigned CNT_W = 10;
    // least times, rounded up to whole cycles
    localparam logic [CNT_W-1:0] DEAD_CYC = CNT_W'((DEAD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] LIMIT_BLANK_CYC = CNT_W'((LIMIT_BLANK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] DECAY_BLANK_CYC = CNT_W'((DECAY_BLANK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] FILTER_CYC = CNT_W'((FILTER_NS * CLK_MHZ + 999) / 1000);
    // gate vector bit positions
    localparam int unsigned G_HIGH_P = 3;
    localparam int unsigned G_LOW_P = 2;
    localparam int unsigned G_HIGH_N = 1;
    localparam int unsigned G_LOW_N = 0;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CHARGE = 2'b01,
        PH_FAST = 2'b10,
        PH_SLOW = 2'b11
    } ccs_phase_t;
endpackage

// ===== rtl/ccs_chop_sequencer.sv
// chop period timing, decay phase sequencing, blanking, filtering and dead time
`timescale 1ns/100ps
// Operation
// - a chop period is exactly sixteen chop oscillator counts
// - phases run charge, fast decay, slow decay inside the period; charge restarts at the next period
// - charge continues until the filtered current-limit comparator fires
// - reaching the current limit moves charge to fast decay
// - reaching the decay-switch level enters slow decay for the rest of period
// - every gate change inserts 400 ns with conflicting transistors off
// - charge not reaching the limit carries over the period boundary
// - fast decay not reaching the decay-switch level carries into next period
// - current-limit comparator ignored for 1.25 us after charge begins
// - decay-switch comparator ignored for 2.2 us after charge ends
// - current-limit pulses shorter than 0.35 us are rejected
// - decay-switch pulses shorter than 0.35 us are rejected
// - without external timing parts, oscillator runs near 0.92 MHz internally
module ccs_chop_sequencer #(
    parameter int unsigned OSC_DIV = ccs_pkg::OSC_DIV_CYC,
    parameter int unsigned CHOP_COUNTS = ccs_pkg::CHOP_COUNTS
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clkEn,
    // control
    input wire logic driveEnable,
    input wire logic currentDir,
    // chop oscillator source
    input wire logic extOscPresent,
    input wire logic extOscTick,
    // comparators
    input wire logic limitCmp,
    input wire logic decayCmp,
    // bridge gates
    output logic gateHighP,
    output logic gateLowP,
    output logic gateHighN,
    output logic gateLowN,
    // status
    output logic [1:0] phase,
    output logic deadActive,
    output logic periodStart
);
    localparam int unsigned DIV_W = $clog2(OSC_DIV + 1);
    localparam int unsigned CHP_W = $clog2(CHOP_COUNTS + 1);
    localparam int unsigned CW = ccs_pkg::CNT_W;

    if (OSC_DIV < 2 || OSC_DIV > 4096) begin : gBadDiv
        $error("OSC_DIV out of range");
    end
    if (CHOP_COUNTS < 2) begin : gBadChop
        $error("CHOP_COUNTS too small");
    end

    // oscillator and period counting
    logic [DIV_W-1:0] divCnt_reg, divCnt_next;
    logic [CHP_W-1:0] chopCnt_reg, chopCnt_next;
    logic periodStart_reg, periodStart_next;
    logic oscTick;

    assign oscTick = extOscPresent ? extOscTick : (divCnt_reg == '0);

    always_comb begin
        divCnt_next = divCnt_reg;
        chopCnt_next = chopCnt_reg;
        periodStart_next = 1'b0;
        if (divCnt_reg == '0) begin
            divCnt_next = DIV_W'(OSC_DIV - 1);
        end else begin
            divCnt_next = divCnt_reg - 1'b1;
        end
        if (oscTick) begin
            if (chopCnt_reg == CHP_W'(CHOP_COUNTS - 1)) begin
                chopCnt_next = '0;
                periodStart_next = 1'b1;
            end else begin
                chopCnt_next = chopCnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            divCnt_reg <= '0;
            chopCnt_reg <= '0;
            periodStart_reg <= 1'b0;
        end else if (clkEn) begin
            divCnt_reg <= divCnt_next;
            chopCnt_reg <= chopCnt_next;
            periodStart_reg <= periodStart_next;
        end
    end

    assign periodStart = periodStart_reg;

    // comparator noise filters; bit 0 limit, bit 1 decay switch
    logic [1:0] cmpRaw;
    logic [1:0] cmpFilt;
    logic [CW-1:0] fltCnt [2];
    assign cmpRaw = {decayCmp, limitCmp};

    for (genvar i = 0; i < 2; i++) begin : gFilt
        logic [CW-1:0] fltCnt_reg, fltCnt_next;
        always_comb begin
            fltCnt_next = '0;
            if (cmpRaw[i]) begin
                fltCnt_next = (fltCnt_reg == ccs_pkg::FILTER_CYC) ? fltCnt_reg : fltCnt_reg + 1'b1;
            end
        end
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                fltCnt_reg <= '0;
            end else if (clkEn) begin
                fltCnt_reg <= fltCnt_next;
            end
        end
        assign cmpFilt[i] = (fltCnt_reg == ccs_pkg::FILTER_CYC);
        assign fltCnt[i] = fltCnt_reg;
    end

    // phase machine with digital blanking
    ccs_pkg::ccs_phase_t phase_reg, phase_next;
    logic [CW-1:0] blankCnt_reg, blankCnt_next;
    logic limitHit, decayHit;

    assign limitHit = cmpFilt[0] && (blankCnt_reg == '0) && (phase_reg == ccs_pkg::PH_CHARGE);
    assign decayHit = cmpFilt[1] && (blankCnt_reg == '0) && (phase_reg == ccs_pkg::PH_FAST);

    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            ccs_pkg::PH_IDLE: begin
                if (periodStart_reg) begin
                    phase_next = ccs_pkg::PH_CHARGE;
                end
            end
            ccs_pkg::PH_CHARGE: begin
                if (limitHit) begin
                    phase_next = ccs_pkg::PH_FAST;
                end
            end
            ccs_pkg::PH_FAST: begin
                // leave only on the decay level or when drive is disabled
                if (decayHit) begin
                    phase_next = ccs_pkg::PH_SLOW;
                end
            end
            ccs_pkg::PH_SLOW: begin
                if (periodStart_reg) begin
                    phase_next = ccs_pkg::PH_CHARGE;
                end
            end
        endcase
        if (!driveEnable) begin
            phase_next = ccs_pkg::PH_IDLE;
        end
        blankCnt_next = (blankCnt_reg == '0) ? blankCnt_reg : blankCnt_reg - 1'b1;
        if (phase_next == ccs_pkg::PH_CHARGE && phase_reg != ccs_pkg::PH_CHARGE) begin
            blankCnt_next = ccs_pkg::LIMIT_BLANK_CYC;
        end
        if (phase_next == ccs_pkg::PH_FAST && phase_reg != ccs_pkg::PH_FAST) begin
            blankCnt_next = ccs_pkg::DECAY_BLANK_CYC;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_reg <= ccs_pkg::PH_IDLE;
            blankCnt_reg <= '0;
        end else if (clkEn) begin
            phase_reg <= phase_next;
            blankCnt_reg <= blankCnt_next;
        end
    end

    assign phase = phase_reg;

    // gate targets and dead time
    logic [3:0] gateTgt;
    logic [3:0] gate_reg, gate_next;
    logic [CW-1:0] deadCnt_reg, deadCnt_next;

    always_comb begin
        gateTgt = 4'h0;
        unique case (phase_reg)
            ccs_pkg::PH_IDLE: gateTgt = 4'h0;
            ccs_pkg::PH_CHARGE: begin
                gateTgt[ccs_pkg::G_HIGH_P] = !currentDir;
                gateTgt[ccs_pkg::G_LOW_N] = !currentDir;
                gateTgt[ccs_pkg::G_HIGH_N] = currentDir;
                gateTgt[ccs_pkg::G_LOW_P] = currentDir;
            end
            // reversed bridge returns energy to the supply
            ccs_pkg::PH_FAST: begin
                gateTgt[ccs_pkg::G_HIGH_P] = currentDir;
                gateTgt[ccs_pkg::G_LOW_N] = currentDir;
                gateTgt[ccs_pkg::G_HIGH_N] = !currentDir;
                gateTgt[ccs_pkg::G_LOW_P] = !currentDir;
            end
            ccs_pkg::PH_SLOW: begin
                gateTgt[ccs_pkg::G_LOW_P] = 1'b1;
                gateTgt[ccs_pkg::G_LOW_N] = 1'b1;
            end
        endcase
    end

    // turn off first, turn on after the full window
    always_comb begin
        gate_next = gate_reg;
        deadCnt_next = deadCnt_reg;
        if ((gate_reg & ~gateTgt) != 4'h0) begin
            // anything newly switching off restarts the window
            gate_next = gate_reg & gateTgt;
            deadCnt_next = ccs_pkg::DEAD_CYC;
        end else if (deadCnt_reg != '0) begin
            deadCnt_next = deadCnt_reg - 1'b1;
            if (deadCnt_reg == CW'(1)) begin
                gate_next = gateTgt;
            end
        end else if (gateTgt != gate_reg) begin
            deadCnt_next = ccs_pkg::DEAD_CYC;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gate_reg <= 4'h0;
            deadCnt_reg <= '0;
        end else if (clkEn) begin
            gate_reg <= gate_next;
            deadCnt_reg <= deadCnt_next;
        end
    end

    assign gateHighP = gate_reg[ccs_pkg::G_HIGH_P];
    assign gateLowP = gate_reg[ccs_pkg::G_LOW_P];
    assign gateHighN = gate_reg[ccs_pkg::G_HIGH_N];
    assign gateLowN = gate_reg[ccs_pkg::G_LOW_N];
    assign deadActive = (deadCnt_reg != '0);

    // checks; helpers only read by assertions
    // a window may restart twice: slow entry, then charge entry, then disable
    localparam int DEAD_MAX = 310;
    logic [CHP_W-1:0] ticksSince;
    logic seenPeriod;
    logic [CW-1:0] deadRun;
    logic [CW-1:0] limRunChk;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ticksSince <= '0;
            seenPeriod <= 1'b0;
            deadRun <= '0;
            limRunChk <= '0;
        end else if (clkEn) begin
            deadRun <= !deadActive ? '0 : (deadRun == '1) ? deadRun : deadRun + 1'b1;
            limRunChk <= !limitCmp ? '0 : (limRunChk == '1) ? limRunChk : limRunChk + 1'b1;
            if (periodStart_reg) begin
                // a source switch can land a tick right after the boundary
                ticksSince <= CHP_W'(oscTick);
                seenPeriod <= 1'b1;
            end else if (oscTick) begin
                ticksSince <= ticksSince + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || !clkEn);

    a_period_len: assert property (periodStart_next && seenPeriod |-> ticksSince == CHP_W'(CHOP_COUNTS - 1))
        else $error("chop period not sixteen counts");
    a_phase_order: assert property (phase_reg == ccs_pkg::PH_FAST |=> phase_reg != ccs_pkg::PH_CHARGE)
        else $error("fast decay jumped to charge");
    a_charge_hold: assert property (phase_reg == ccs_pkg::PH_CHARGE && !limitHit && driveEnable
        |=> phase_reg == ccs_pkg::PH_CHARGE)
        else $error("charge left without limit");
    a_fast_entry: assert property (limitHit && driveEnable |=> phase_reg == ccs_pkg::PH_FAST)
        else $error("limit did not start fast decay");
    a_slow_hold: assert property (phase_reg == ccs_pkg::PH_SLOW && !periodStart_reg && driveEnable
        |=> phase_reg == ccs_pkg::PH_SLOW)
        else $error("slow decay ended early");
    a_no_shoot: assert property (!(gate_reg[ccs_pkg::G_HIGH_P] && gate_reg[ccs_pkg::G_LOW_P])
        && !(gate_reg[ccs_pkg::G_HIGH_N] && gate_reg[ccs_pkg::G_LOW_N]))
        else $error("shoot-through on a leg");
    a_dead_window: assert property ($fell(deadActive) |-> deadRun >= ccs_pkg::DEAD_CYC)
        else $error("dead time too short");
    a_dead_end: assert property ($rose(deadActive) |-> ##[1:DEAD_MAX] !deadActive)
        else $error("dead time never ended");
    a_fast_carry: assert property (phase_reg == ccs_pkg::PH_FAST && periodStart_reg && !decayHit
        && driveEnable |=> phase_reg == ccs_pkg::PH_FAST)
        else $error("fast decay cut at period edge");
    a_limit_blank: assert property ($rose(phase_reg == ccs_pkg::PH_CHARGE)
        |-> blankCnt_reg == ccs_pkg::LIMIT_BLANK_CYC)
        else $error("limit blank not loaded");
    a_decay_blank: assert property ($rose(phase_reg == ccs_pkg::PH_FAST)
        |-> blankCnt_reg == ccs_pkg::DECAY_BLANK_CYC)
        else $error("decay blank not loaded");
    a_limit_filter: assert property (cmpFilt[0] |-> fltCnt[0] == ccs_pkg::FILTER_CYC
        && limRunChk >= ccs_pkg::FILTER_CYC)
        else $error("limit filter passed a short pulse");
    a_decay_filter: assert property (!decayCmp |=> !cmpFilt[1])
        else $error("decay filter held after release");
    a_osc_tick: assert property (!extOscPresent && oscTick |=> !oscTick)
        else $error("internal oscillator tick too fast");
    a_period_charge: assert property (phase_reg == ccs_pkg::PH_SLOW && periodStart_reg && driveEnable
        |=> phase_reg == ccs_pkg::PH_CHARGE)
        else $error("period did not restart charge");

    c_fast: cover property (phase_reg == ccs_pkg::PH_CHARGE ##1 phase_reg == ccs_pkg::PH_FAST);
    c_slow: cover property (phase_reg == ccs_pkg::PH_FAST ##1 phase_reg == ccs_pkg::PH_SLOW);
    c_restart: cover property (phase_reg == ccs_pkg::PH_SLOW ##1 phase_reg == ccs_pkg::PH_CHARGE);
    c_charge_carry: cover property (phase_reg == ccs_pkg::PH_CHARGE && periodStart_reg);
endmodule

// ===== tb/ccs_bridge_model.sv
// behavioural winding current and comparators facing the chop sequencer
`timescale 1ns/100ps
module ccs_bridge_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // bridge gates and winding polarity
    input wire logic gateHighP,
    input wire logic gateLowP,
    input wire logic gateHighN,
    input wire logic gateLowN,
    input wire logic currentDir,
    // trip levels and injected noise
    input wire logic signed [31:0] limitLevel,
    input wire logic signed [31:0] decayLevel,
    input wire logic limitSpike,
    input wire logic decaySpike,
    // comparators
    output logic limitCmp,
    output logic decayCmp
);
    logic signed [31:0] curReg;
    logic signed [31:0] curNext;
    logic drivePair;
    logic backPair;
    assign drivePair = currentDir ? (gateHighN && gateLowP) : (gateHighP && gateLowN);
    assign backPair = currentDir ? (gateHighP && gateLowN) : (gateHighN && gateLowP);
    // slow decay and dead time both bleed current, fast decay returns it quickly
    always_comb begin
        curNext = drivePair ? curReg + 32'sh2 : (backPair ? curReg - 32'sh3 : curReg - 32'sh1);
        if (curNext < 32'sh0) begin
            curNext = 32'sh0;
        end
    end
    always_ff @(posedge clk_sys) begin
        curReg <= srst ? 32'sh0 : curNext;
    end
    // noise pulses ride on top of the true comparator result
    assign limitCmp = (curReg >= limitLevel) || limitSpike;
    assign decayCmp = (curReg <= decayLevel) || decaySpike;
endmodule

// ===== tb/constant_current_chop_sequencer_tb_top.sv
// self-checking bench for the chop sequencer with a behavioural bridge
`timescale 1ns/100ps
module constant_current_chop_sequencer_tb_top;
    localparam int OSC_DIV = 64;
    localparam int EXT_DIV = 40;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic driveEnable = 1'b0;
    logic currentDir = 1'b0;
    logic extOscPresent = 1'b0;
    logic extOscTick = 1'b0;
    logic limitCmp, decayCmp, gateHighP, gateLowP, gateHighN, gateLowN, deadActive, periodStart;
    logic [1:0] phase;
    logic [1:0] prevPh = 2'h0;
    logic [3:0] gates;
    logic [3:0] prevGates = 4'h0;
    logic prevStart = 1'b0;
    logic signed [31:0] limitLevel = 32'sh64;
    logic signed [31:0] decayLevel = 32'sh5;
    logic limitSpike = 1'b0;
    logic decaySpike = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    int limRun = 0, decRun = 0, phCnt = 0, offCnt = 0, perCnt = 0, perSkip = 1, tickCnt = 0;
    int expPer = 16 * OSC_DIV;
    int seedVal;
    logic limOk, decOk;
    assign gates = {gateHighP, gateLowP, gateHighN, gateLowN};
    assign limOk = phCnt >= ccs_pkg::LIMIT_BLANK_CYC - 1 && limRun >= ccs_pkg::FILTER_CYC - 2;
    assign decOk = phCnt >= ccs_pkg::DECAY_BLANK_CYC - 1 && decRun >= ccs_pkg::FILTER_CYC - 2;
    always #2 clk_sys = ~clk_sys;
    ccs_chop_sequencer #(.OSC_DIV(OSC_DIV), .CHOP_COUNTS(16)) i_ccs_chop_sequencer (.clk_sys(clk_sys),
        .srst(srst), .clkEn(1'b1), .driveEnable(driveEnable), .currentDir(currentDir),
        .extOscPresent(extOscPresent), .extOscTick(extOscTick), .limitCmp(limitCmp), .decayCmp(decayCmp),
        .gateHighP(gateHighP), .gateLowP(gateLowP), .gateHighN(gateHighN), .gateLowN(gateLowN),
        .phase(phase), .deadActive(deadActive), .periodStart(periodStart));
    ccs_bridge_model i_ccs_bridge_model (.clk_sys(clk_sys), .srst(srst), .gateHighP(gateHighP),
        .gateLowP(gateLowP), .gateHighN(gateHighN), .gateLowN(gateLowN), .currentDir(currentDir),
        .limitLevel(limitLevel), .decayLevel(decayLevel), .limitSpike(limitSpike),
        .decaySpike(decaySpike), .limitCmp(limitCmp), .decayCmp(decayCmp));
    // {highP, lowP, highN, lowN} that pushes current the chosen way
    function automatic logic [3:0] driveVec(input logic dir);
        return dir ? 4'h6 : 4'h9;
    endfunction
    task automatic checkNum(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic checkBit(input string what, input logic exp, input logic got);
        checkNum(what, 32'(exp), 32'(got));
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic waitPhase(input logic [1:0] p, input int bound);
        int n;
        n = 0;
        while (phase !== p && n < bound) begin
            @(posedge clk_sys);
            n++;
        end
        checkNum("phase reached", 32'(p), 32'(phase));
    endtask
    // returns two edges after a boundary so the new phase is visible
    task automatic waitStart();
        do @(posedge clk_sys); while (periodStart !== 1'b1);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic pulse(input logic onLimit, input int n);
        if (onLimit) limitSpike <= 1'b1; else decaySpike <= 1'b1;
        repeat (n) @(posedge clk_sys);
        limitSpike <= 1'b0;
        decaySpike <= 1'b0;
        repeat (20) @(posedge clk_sys);
    endtask
    // external oscillator counts arrive as single-cycle ticks
    always @(posedge clk_sys) begin
        tickCnt <= (tickCnt == EXT_DIV - 1) ? 0 : tickCnt + 1;
        extOscTick <= extOscPresent && (tickCnt == EXT_DIV - 1);
    end
    always @(posedge clk_sys) begin
        if (srst) begin
            phCnt <= 0;
            offCnt <= 0;
        end else begin
            limRun <= limitCmp ? limRun + 1 : 0;
            decRun <= decayCmp ? decRun + 1 : 0;
            prevPh <= phase;
            prevStart <= periodStart;
            prevGates <= gates;
            perCnt <= periodStart ? 1 : perCnt + 1;
            phCnt <= (phase != prevPh) ? 1 : phCnt + 1;
            offCnt <= ((prevGates & ~gates) != 4'h0) ? 1 : offCnt + 1;
            if (phase != prevPh) begin
                case ({prevPh, phase})
                    4'h1, 4'hd: checkBit("charge at boundary", 1'b1, prevStart);
                    4'h6: checkBit("limit blank filter", 1'b1, limOk);
                    4'hb: checkBit("decay blank filter", 1'b1, decOk);
                    4'h4, 4'h8, 4'hc: checkBit("idle only when disabled", 1'b0, driveEnable);
                    default: checkNum("phase order", 32'(prevPh), 32'(phase));
                endcase
            end
            if ((gates & ~prevGates) != 4'h0) checkBit("dead time", 1'b1, offCnt >= ccs_pkg::DEAD_CYC);
            if ((gateHighP && gateLowP) || (gateHighN && gateLowN)) checkBit("shoot-through", 1'b0, 1'b1);
            if (phCnt == ccs_pkg::DEAD_CYC + 4 && phase == ccs_pkg::PH_CHARGE) begin
                checkNum("charge gates", 32'(driveVec(currentDir)), 32'(gates));
            end
            if (phCnt == ccs_pkg::DEAD_CYC + 4 && phase == ccs_pkg::PH_FAST) begin
                checkNum("fast gates", 32'(driveVec(!currentDir)), 32'(gates));
            end
            if (periodStart) begin
                if (perSkip > 0) perSkip <= perSkip - 1;
                else checkNum("period length", expPer, perCnt);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        end_of_test();
    end
    initial begin
        seedVal = $urandom(32'h1e9f);
        repeat (20) @(posedge clk_sys);
        checkNum("reset outputs", 32'h0, 32'({gates, phase, deadActive, periodStart}));
        srst <= 1'b0;
        driveEnable <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            waitStart();
            currentDir <= 1'($urandom % 2);
            limitLevel <= 32'($urandom % 260) + 32'sh28;
            decayLevel <= 32'($urandom % 20);
            waitPhase(ccs_pkg::PH_SLOW, 3000);
            waitStart();
            checkNum("charge after slow", 32'(ccs_pkg::PH_CHARGE), 32'(phase));
        end
        $display("test mixed decay loop done");
        limitLevel <= 32'sh7fffffff;
        decayLevel <= -32'sh1;
        waitStart();
        waitStart();
        checkNum("charge carry", 32'(ccs_pkg::PH_CHARGE), 32'(phase));
        pulse(1'b1, ccs_pkg::FILTER_CYC - 1);
        checkNum("short limit pulse", 32'(ccs_pkg::PH_CHARGE), 32'(phase));
        pulse(1'b1, ccs_pkg::FILTER_CYC + 4 + $urandom % 8);
        waitPhase(ccs_pkg::PH_FAST, 20);
        repeat (600) @(posedge clk_sys);
        pulse(1'b0, ccs_pkg::FILTER_CYC - 1);
        checkNum("short decay pulse", 32'(ccs_pkg::PH_FAST), 32'(phase));
        waitStart();
        checkNum("fast carry", 32'(ccs_pkg::PH_FAST), 32'(phase));
        pulse(1'b0, ccs_pkg::FILTER_CYC + 4);
        waitPhase(ccs_pkg::PH_SLOW, 20);
        $display("test carry and noise done");
        limitLevel <= 32'sh64;
        decayLevel <= 32'sh5;
        perSkip <= 2;
        expPer <= 16 * EXT_DIV;
        extOscPresent <= 1'b1;
        repeat (6 * 16 * EXT_DIV) @(posedge clk_sys);
        perSkip <= 2;
        expPer <= 16 * OSC_DIV;
        extOscPresent <= 1'b0;
        repeat (4 * 16 * OSC_DIV) @(posedge clk_sys);
        $display("test oscillator source done");
        driveEnable <= 1'b0;
        repeat (320) @(posedge clk_sys);
        checkNum("disabled bridge", 32'h0, 32'({phase, gates}));
        driveEnable <= 1'b1;
        waitStart();
        checkNum("charge after enable", 32'(ccs_pkg::PH_CHARGE), 32'(phase));
        $display("test drive disable done");
        end_of_test();
    end
endmodule
